// ===== design/fces_pkg.sv
package fces_pkg;
  // ---------------------------------------------------------------------
  // bus widths and command codes
  // ---------------------------------------------------------------------
  localparam int        ADDR_W        = 20;
  localparam int        CMD_ADDR_W    = 11;
  localparam logic [10:0] UNLOCK1_ADDR = 11'h555;
  localparam logic [10:0] UNLOCK2_ADDR = 11'h2aa;
  localparam logic [7:0] UNLOCK1_DATA  = 8'haa;
  localparam logic [7:0] UNLOCK2_DATA  = 8'h55;
  localparam logic [7:0] CMD_RESET     = 8'hf0;
  localparam logic [7:0] CMD_IDENT     = 8'h90;
  localparam logic [7:0] CMD_PROGRAM   = 8'ha0;
  localparam logic [7:0] CMD_ERASE_SET = 8'h80;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_BLOCK_SEL = 8'h30;
  localparam logic [7:0] CMD_SUSPEND   = 8'hb0;
  localparam logic [7:0] CMD_RESUME    = 8'h30;
  // status bits read back while polling
  localparam int        TOGGLE_BIT    = 6;
  localparam int        ERROR_BIT     = 5;
  // ---------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------
  localparam int        CLK_MHZ       = 25;
  localparam int        SUSPEND_US    = 15;
  localparam int        SUSPEND_CYC   = SUSPEND_US * CLK_MHZ;
  localparam int        WRITE_LOW_CYC = 2;

  // host request
  typedef enum logic [2:0] {
    FCES_OP_RESET   = 3'h0,
    FCES_OP_IDENT   = 3'h1,
    FCES_OP_PROGRAM = 3'h2,
    FCES_OP_CHIP    = 3'h3,
    FCES_OP_BLOCK   = 3'h4,
    FCES_OP_SUSPEND = 3'h5,
    FCES_OP_RESUME  = 3'h6,
    FCES_OP_READ    = 3'h7
  } fces_op_type;

  typedef struct packed {
    fces_op_type       op;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } fces_req_type;

  // flash pins driven by the host
  typedef struct packed {
    logic              chip_en_n;
    logic              out_en_n;
    logic              wr_en_n;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        dq;
    logic              dq_oe;
  } fces_pins_type;
endpackage

// ===== design/fces_host.sv
`timescale 1ns/10ps
module fces_host #(
  parameter int SUSPEND_WAIT = fces_pkg::SUSPEND_CYC
) (
  input  wire logic                 REF_CLK_IN,
  input  wire logic                 RST_IN,
  input  wire fces_pkg::fces_req_type REQ_IN,
  input  wire logic                 REQ_VALID_IN,
  output logic                      REQ_READY_OUT,
  output logic                      DONE_OUT,
  output logic                      ERROR_OUT,
  output logic [7:0]                RDATA_OUT,
  input  wire logic [7:0]           DQ_IN,
  output fces_pkg::fces_pins_type   PINS_OUT
);
  // ---------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    FCES_IDLE  = 3'b000,
    FCES_WRITE = 3'b001,
    FCES_GAP   = 3'b010,
    FCES_READ  = 3'b011,
    FCES_POLL  = 3'b100,
    FCES_WAIT  = 3'b101
  } fces_state_type;

  typedef struct packed {
    fces_state_type        st;
    fces_pkg::fces_req_type req;
    logic [2:0]            idx;
    logic [2:0]            len;
    logic [15:0]           cnt;
    logic                  tog;
    logic                  first;
    logic                  done;
    logic                  err;
    logic [7:0]            rdata;
    fces_pkg::fces_pins_type pins;
  } fces_host_type;

  fces_host_type s_r;
  fces_host_type s_nxt;

  // ---------------------------------------------------------------------
  // command table: address and data of write number idx
  // ---------------------------------------------------------------------
  function automatic logic [27:0] step(input fces_pkg::fces_req_type r,
                                       input logic [2:0] i);
    logic [10:0] a;
    logic [7:0]  d;
    logic [19:0] full;
    a = fces_pkg::UNLOCK1_ADDR;
    d = fces_pkg::UNLOCK1_DATA;
    full = r.addr;
    if (i == 3'h1 || i == 3'h4) begin // unlock two
      a = fces_pkg::UNLOCK2_ADDR;
      d = fces_pkg::UNLOCK2_DATA;
    end
    if (i == 3'h2) begin
      unique case (r.op)
        fces_pkg::FCES_OP_IDENT:   d = fces_pkg::CMD_IDENT;
        fces_pkg::FCES_OP_PROGRAM: d = fces_pkg::CMD_PROGRAM;
        fces_pkg::FCES_OP_RESET:   d = fces_pkg::CMD_RESET;
        default:                   d = fces_pkg::CMD_ERASE_SET;
      endcase
    end
    if (i == 3'h3 && r.op == fces_pkg::FCES_OP_PROGRAM) begin
      return {full, r.data}; // target address and byte
    end
    if (i == 3'h5) begin
      if (r.op == fces_pkg::FCES_OP_CHIP) begin
        d = fces_pkg::CMD_CHIP_ERASE;
      end else begin
        return {full, fces_pkg::CMD_BLOCK_SEL}; // block address
      end
    end
    // only low address bits matter to the device
    return {9'h000, a, d};
  endfunction

  // ---------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------
  always_comb begin
    logic [27:0] w;
    s_nxt = s_r;
    w = step(s_r.req, s_r.idx);
    s_nxt.done = 1'b0;
    unique case (s_r.st)
      FCES_IDLE: begin
        if (REQ_VALID_IN) begin
          s_nxt.req = REQ_IN;
          s_nxt.idx = 3'h0;
          s_nxt.err = 1'b0;
          s_nxt.first = 1'b1;
          s_nxt.st = FCES_WRITE;
          unique case (REQ_IN.op)
            fces_pkg::FCES_OP_RESET:   s_nxt.len = 3'h3;
            fces_pkg::FCES_OP_IDENT:   s_nxt.len = 3'h3;
            fces_pkg::FCES_OP_PROGRAM: s_nxt.len = 3'h4;
            fces_pkg::FCES_OP_CHIP:    s_nxt.len = 3'h6;
            fces_pkg::FCES_OP_BLOCK:   s_nxt.len = 3'h6;
            default:                   s_nxt.len = 3'h1;
          endcase
          if (REQ_IN.op == fces_pkg::FCES_OP_SUSPEND) begin
            s_nxt.req.data = fces_pkg::CMD_SUSPEND;
          end else if (REQ_IN.op == fces_pkg::FCES_OP_RESUME) begin
            s_nxt.req.data = fces_pkg::CMD_RESUME;
          end else if (REQ_IN.op == fces_pkg::FCES_OP_READ) begin
            s_nxt.st = FCES_READ;
          end
        end
      end
      FCES_WRITE: begin
        // single-write commands place data at any address
        s_nxt.pins.chip_en_n = 1'b0;
        s_nxt.pins.wr_en_n = 1'b0;
        s_nxt.pins.dq_oe = 1'b1;
        if (s_r.len == 3'h1) begin
          s_nxt.pins.addr = s_r.req.addr;
          s_nxt.pins.dq = s_r.req.data;
        end else begin
          s_nxt.pins.addr = w[27:8];
          s_nxt.pins.dq = w[7:0];
        end
        s_nxt.cnt = 16'(fces_pkg::WRITE_LOW_CYC);
        s_nxt.st = FCES_GAP;
      end
      FCES_GAP: begin
        if (s_r.cnt != 16'h0000) begin
          s_nxt.cnt = s_r.cnt - 16'h0001;
        end else if (!s_r.pins.wr_en_n) begin
          s_nxt.pins.wr_en_n = 1'b1; // rising edge latches the write
          s_nxt.pins.chip_en_n = 1'b1;
        end else if (s_r.idx + 3'h1 < s_r.len) begin
          s_nxt.idx = s_r.idx + 3'h1;
          s_nxt.st = FCES_WRITE;
        end else begin
          s_nxt.pins.dq_oe = 1'b0;
          unique case (s_r.req.op)
            fces_pkg::FCES_OP_PROGRAM, fces_pkg::FCES_OP_CHIP,
            fces_pkg::FCES_OP_BLOCK, fces_pkg::FCES_OP_RESUME:
              s_nxt.st = FCES_POLL; // status readable at once
            fces_pkg::FCES_OP_SUSPEND: begin
              s_nxt.cnt = 16'(SUSPEND_WAIT); // halt latency
              s_nxt.st = FCES_WAIT;
            end
            default: begin
              s_nxt.done = 1'b1;
              s_nxt.st = FCES_IDLE;
            end
          endcase
        end
      end
      FCES_READ, FCES_POLL: begin
        // one read cycle: strobe, then sample on the next step
        if (s_r.pins.out_en_n) begin
          s_nxt.pins.chip_en_n = 1'b0;
          s_nxt.pins.out_en_n = 1'b0;
          s_nxt.pins.addr = s_r.req.addr;
        end else begin
          s_nxt.pins.chip_en_n = 1'b1;
          s_nxt.pins.out_en_n = 1'b1;
          s_nxt.rdata = DQ_IN;
          s_nxt.tog = DQ_IN[fces_pkg::TOGGLE_BIT];
          s_nxt.first = 1'b0;
          if (s_r.st == FCES_READ) begin
            s_nxt.done = 1'b1;
            s_nxt.st = FCES_IDLE;
          end else if (!s_r.first &&
                       DQ_IN[fces_pkg::TOGGLE_BIT] == s_r.tog) begin
            s_nxt.done = 1'b1; // toggle stopped: back to array
            s_nxt.st = FCES_IDLE;
          end else if (!s_r.first && DQ_IN[fces_pkg::ERROR_BIT]) begin
            s_nxt.err = 1'b1; // failure: host must send reset next
            s_nxt.done = 1'b1;
            s_nxt.st = FCES_IDLE;
          end
        end
      end
      FCES_WAIT: begin
        if (s_r.cnt != 16'h0000) begin
          s_nxt.cnt = s_r.cnt - 16'h0001;
        end else begin
          s_nxt.done = 1'b1;
          s_nxt.st = FCES_IDLE;
        end
      end
      default: s_nxt.st = FCES_IDLE;
    endcase
  end

  // ---------------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------------
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      s_r <= '0;
      s_r.pins.chip_en_n <= 1'b1;
      s_r.pins.out_en_n <= 1'b1;
      s_r.pins.wr_en_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs
  assign REQ_READY_OUT = (s_r.st == FCES_IDLE);
  assign DONE_OUT      = s_r.done;
  assign ERROR_OUT     = s_r.err;
  assign RDATA_OUT     = s_r.rdata;
  assign PINS_OUT      = s_r.pins;

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  wr_no_read_a : assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    !(!s_r.pins.wr_en_n && !s_r.pins.out_en_n))
    else $error("write and output enable low together");
  unlock_first_a : assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    (s_r.st == FCES_WRITE && s_r.idx == 3'h0 && s_r.len != 3'h1)
    |=> s_r.pins.dq == fces_pkg::UNLOCK1_DATA)
    else $error("sequence did not open with unlock byte");

  // completion is one cycle wide so a request is never reported twice
  done_pulse_a : assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    s_r.done |=> !s_r.done)
    else $error("done held longer than one cycle");

  // address and data stand while the write strobe rises
  we_hold_a : assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    $rose(s_r.pins.wr_en_n)
    |-> $stable(s_r.pins.addr) && $stable(s_r.pins.dq))
    else $error("write address or data moved at strobe rise");

  // write strobe stays low for the full pulse width
  we_width_a : assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    $fell(s_r.pins.wr_en_n)
    |=> (!s_r.pins.wr_en_n) [*2] ##1 s_r.pins.wr_en_n)
    else $error("write strobe width wrong");

  // polling and reading never write and never drive the data bus
  poll_read_a : assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    (s_r.st == FCES_POLL || s_r.st == FCES_READ)
    |-> s_r.pins.wr_en_n && !s_r.pins.dq_oe)
    else $error("bus driven while reading status");

  // a seen failure stays flagged until the next request is taken
  err_hold_a : assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    s_r.err && !REQ_VALID_IN |=> s_r.err)
    else $error("error flag dropped without a new request");

  // suspend wait ends after the halt latency
  localparam int SUSP_MAX = SUSPEND_WAIT + 1;
  susp_done_a : assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    $rose(s_r.st == FCES_WAIT) |-> ##[1:SUSP_MAX] s_r.done)
    else $error("suspend wait did not finish in time");
endmodule

// ===== sim/fces_flash_model.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// flash device seen from the host pins
// ---------------------------------------------------------------
module fces_flash_model #(
  parameter logic [15:0] PROT  = 16'h0004,
  parameter logic [7:0]  MAKER = 8'h5a, // arbitrary value
  parameter logic [7:0]  PART  = 8'h3c, // arbitrary value
  parameter int          WIN   = 10,
  parameter int          BUSY  = 40
) (
  input  wire logic                    clk_in,
  input  wire logic                    rst_in,
  input  wire logic                    fail_in,
  input  wire fces_pkg::fces_pins_type pins_in,
  output logic [7:0]                   dq_out
);
  logic [7:0]  mem [int];
  int          cnt;
  int          k[$];
  logic [2:0]  seq;
  logic [3:0]  blk;
  logic        we_q, oe_q, tog, err, ident, chip, ers, susp;
  logic [7:0]  last, d;
  logic [19:0] a;

  function automatic logic [7:0] rd(input logic [19:0] x);
    return mem.exists(x) ? mem[x] : 8'hff;
  endfunction

  // read path; a released bus shows the inverse of the last byte
  always @* begin
    if (!pins_in.chip_en_n && !pins_in.out_en_n)
      dq_out = (cnt > 0 || err) && !susp ? {1'b0, tog, err, 5'h0}
             : ident ? (pins_in.addr[0] ? PART : MAKER)
             : rd(pins_in.addr);
    else
      dq_out = ~last;
  end

  // timers, strobe edges and command decoding; state moves on the
  // falling edge so the host's rising-edge sample sees a settled bus
  always @(negedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt = 0;
      seq = 3'h0;
      {we_q, oe_q, tog, err, ident, chip, ers, susp} = 8'hc0;
      last = 8'h00;
    end else begin
      if (!pins_in.chip_en_n && !pins_in.out_en_n)
        last = dq_out; // value shown while the read strobe is low
      if (pins_in.out_en_n && !oe_q) begin
        tog = tog ^ (cnt > 0 || err);
      end
      if (cnt > 0 && !susp) begin
        if (cnt == 1 && ers && fail_in)
          err = 1'b1;
        else if (cnt == 1 && ers) begin
          k.delete();
          foreach (mem[i])
            if (!PROT[(i >> 16) & 15] && (chip || (i >> 16) == blk))
              k.push_back(i);
          foreach (k[j])
            mem.delete(k[j]);
        end
        cnt--;
      end
      if (pins_in.wr_en_n && !we_q) begin
        d = pins_in.dq;
        a = pins_in.addr;
        if (cnt > 0 && chip)
          seq = 3'h0;
        else if (seq == 3'h6) begin
          if (!PROT[a[19:16]])
            mem[a] = rd(a) & d;
          {ers, chip, seq} = 5'h0;
          cnt = BUSY;
        end else if (d == 8'hf0) begin
          {seq, err, ident} = 5'h0;
          if (!susp)
            cnt = 0;
        end else if (cnt > 0 && !susp)
          susp = d == 8'hb0 && ers;
        else if (susp && d == 8'h30 && seq == 3'h0)
          susp = 1'b0;
        else case (seq)
          3'h0: seq = a[10:0] == 11'h555 && d == 8'haa ? 3'h1 : 3'h0;
          3'h1: seq = a[10:0] == 11'h2aa && d == 8'h55 ? 3'h2 : 3'h0;
          3'h3: seq = a[10:0] == 11'h555 && d == 8'haa ? 3'h4 : 3'h0;
          3'h4: seq = a[10:0] == 11'h2aa && d == 8'h55 ? 3'h5 : 3'h0;
          3'h2: begin
            ident = a[10:0] == 11'h555 && d == 8'h90;
            seq = a[10:0] != 11'h555 ? 3'h0 : d == 8'ha0 ? 3'h6
                : d == 8'h80 ? 3'h3 : 3'h0;
          end
          default: begin
            chip = a[10:0] == 11'h555 && d == 8'h10;
            ers = chip || d == 8'h30;
            blk = a[19:16];
            cnt = chip ? BUSY : d == 8'h30 ? WIN + BUSY : 0;
            seq = 3'h0;
          end
        endcase
      end
      we_q = pins_in.wr_en_n;
      oe_q = pins_in.out_en_n;
    end
  end
endmodule

// ===== sim/tb_top.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// host controller against the device model
// ---------------------------------------------------------------
module tb_top;
  localparam logic [7:0] MAKER = 8'h5a; // arbitrary value
  localparam logic [7:0] PART  = 8'h3c; // arbitrary value
  logic                    clk, rst, vld, fail, rdy, done, err;
  logic [7:0]              rdata, dq;
  fces_pkg::fces_req_type  rq;
  fces_pkg::fces_pins_type pins;
  int                      n_errors, cmp_count, cyc;

  fces_host #(.SUSPEND_WAIT(4)) fces_host_i (
    .REF_CLK_IN(clk), .RST_IN(rst), .REQ_IN(rq), .REQ_VALID_IN(vld),
    .REQ_READY_OUT(rdy), .DONE_OUT(done), .ERROR_OUT(err),
    .RDATA_OUT(rdata), .DQ_IN(dq), .PINS_OUT(pins));
  fces_flash_model #(.MAKER(MAKER), .PART(PART)) fces_flash_model_i (
    .clk_in(clk), .rst_in(rst), .fail_in(fail), .pins_in(pins),
    .dq_out(dq));

  // clock and hang limit
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end

  task print_verdict;
    $display("checks %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one request, offered for one cycle once ready is seen, then wait for its completion
  task req(input fces_pkg::fces_op_type op, input logic [19:0] a,
           input logic [7:0] d);
    int n;
    n = 0;
    @(negedge clk);
    while (rdy !== 1'b1) @(negedge clk);
    rq = '{op, a, d};
    vld = 1'b1;
    @(negedge clk);
    vld = 1'b0;
    while (done !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 3000)
      n_errors++; // request never completed
  endtask

  task rchk(input string nm, input logic [19:0] a, input logic [7:0] e);
    req(fces_pkg::FCES_OP_READ, a, 8'h00);
    chk(nm, rdata, e);
  endtask

  task t_prog;
    req(fces_pkg::FCES_OP_PROGRAM, 20'h10005, 8'h3c);
    rchk("prog", 20'h10005, 8'h3c);
    req(fces_pkg::FCES_OP_PROGRAM, 20'h10005, 8'h0f);
    rchk("clear_only", 20'h10005, 8'h0c);
    req(fces_pkg::FCES_OP_PROGRAM, 20'h20001, 8'h00);
    rchk("protected", 20'h20001, 8'hff);
  endtask

  task t_block;
    req(fces_pkg::FCES_OP_PROGRAM, 20'h30002, 8'h55);
    req(fces_pkg::FCES_OP_BLOCK, 20'h1abcd, 8'h00);
    rchk("blk_erased", 20'h10005, 8'hff);
    rchk("blk_other", 20'h30002, 8'h55);
    req(fces_pkg::FCES_OP_BLOCK, 20'h20000, 8'h00);
    chk("blk_prot_err", {7'h0, err}, 8'h00);
  endtask

  task t_ident;
    req(fces_pkg::FCES_OP_IDENT, 20'hfe000, 8'h00);
    rchk("maker", 20'h00000, MAKER);
    rchk("part", 20'h40001, PART);
    req(fces_pkg::FCES_OP_RESET, 20'h00000, 8'h00);
    rchk("after_reset", 20'h30002, 8'h55);
  endtask

  task t_chip;
    req(fces_pkg::FCES_OP_CHIP, 20'h00000, 8'h00);
    rchk("chip", 20'h30002, 8'hff);
    fail = 1'b1;
    req(fces_pkg::FCES_OP_CHIP, 20'h00000, 8'h00);
    chk("fail_flag", {7'h0, err}, 8'h01);
    req(fces_pkg::FCES_OP_READ, 20'h30002, 8'h00);
    chk("fail_status", rdata & 8'h20, 8'h20);
    fail = 1'b0;
    req(fces_pkg::FCES_OP_RESET, 20'h00000, 8'h00);
    rchk("recover", 20'h30002, 8'hff);
  endtask

  task t_susp;
    req(fces_pkg::FCES_OP_SUSPEND, 20'hc1234, 8'h00);
    chk("susp_byte", pins.dq, fces_pkg::CMD_SUSPEND);
    rchk("susp_read", 20'h30002, 8'hff);
    req(fces_pkg::FCES_OP_RESUME, 20'hc1234, 8'h00);
    chk("resume_byte", pins.dq, fces_pkg::CMD_RESUME);
    rchk("resume_read", 20'h30002, 8'hff);
  endtask

  initial begin
    rst = 1'b1;
    vld = 1'b0;
    fail = 1'b0;
    rq = '0;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    t_prog();
    t_block();
    t_ident();
    t_chip();
    t_susp();
    print_verdict();
  end
endmodule
